// ---- rtl/usb_core_clock_select.sv ----
// Clock selection block: PLL prescaler, core postscaler, USB clock and oscillator tuning.
//
// Notes on behaviour
// - USB module gets 6 MHz in low-speed, 48 MHz in full-speed mode.
// - Low-speed USB clock comes from primary chain, divided by four, not PLL.
// - Low-speed USB active with primary oscillator mode requires a 24 MHz core clock.
// - The 24 MHz restriction is lifted for secondary or internal oscillator sources.
// - USB clock may run from primary oscillator while core runs slower elsewhere.
// - Tuning value trims the fast internal oscillator only, never the slow RC.
// - Prescaler codes 111, 110, 101 divide by 12, 10 and 6.
// - 40/48 MHz inputs allow external-clock modes only; 24 MHz also allows high-speed crystal.
// - Non-PLL postscaler codes 00..11 divide by 1, 2, 3 and 4.
// - PLL postscaler codes 00..11 give 48, 32, 24 and 16 MHz core clocks.
// - 24 MHz high-speed crystal without PLL gives 24, 12, 8, 6 MHz.
// - Tuning field is two's complement: 01111 max, 00000 centre, 10000 minimum.
// - Direct 48 MHz USB clock is used only while usb_clock_source_sel is cleared.
`timescale 1ns/1ps
`default_nettype none

module usb_core_clock_select
  import clock_select_pkg::*;
#(
  parameter int SLOW_RC_DIV = 6451
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [DATA_WIDTH-1:0] pwdata,
  output var logic [DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic osc_tick,
  input wire logic pll_tick,
  input wire logic sec_osc_tick,
  input wire logic usb_active,
  output var logic pll_ref_tick,
  output var logic core_tick,
  output var logic usb_tick,
  output var logic fast_internal_osc,
  output var logic slow_internal_rc,
  output var logic [TUNE_WIDTH-1:0] osc_tuning_value,
  output var logic low_speed_violation,
  output var logic mode_not_allowed
);

  localparam int SLOW_WIDTH = $clog2(SLOW_RC_DIV + 1);
  localparam logic [SLOW_WIDTH-1:0] SLOW_LAST = SLOW_WIDTH'(SLOW_RC_DIV - 1);
  localparam logic [SLOW_WIDTH-1:0] SLOW_ZERO = '0;
  localparam logic [RATIO_WIDTH-1:0] RATIO_ONE = 4'h1;
  localparam logic [RATIO_WIDTH-1:0] CNT_ZERO = 4'h0;

  // ----------------------------------------------------------------------
  // State record
  // ----------------------------------------------------------------------
  typedef struct packed {
    clock_mode_type clock_mode_sel;
    logic [2:0] pll_prescale_sel;
    logic [1:0] core_postscale_sel;
    logic usb_clock_source_sel;
    logic usb_low_speed;
    logic [FREQ_WIDTH-1:0] osc_freq_mhz;
    logic [TUNE_WIDTH-1:0] tune;
    logic usb_active_meta;
    logic usb_active_sync;
    logic [RATIO_WIDTH-1:0] prescale_cnt;
    logic [RATIO_WIDTH-1:0] core_cnt;
    logic [RATIO_WIDTH-1:0] usb_cnt;
    logic pll_ref_tick;
    logic core_tick;
    logic usb_tick;
    logic [ACC_WIDTH-1:0] fast_acc;
    logic fast_tick;
    logic [SLOW_WIDTH-1:0] slow_cnt;
    logic slow_tick;
    logic [DATA_WIDTH-1:0] prdata;
  } state_type;

  state_type cur;
  state_type next_cur;

  // ----------------------------------------------------------------------
  // Decoded configuration
  // ----------------------------------------------------------------------
  logic pll_mode;
  logic primary_mode;
  logic ext_mode;
  logic hs_mode;
  logic mode_defined;
  logic [RATIO_WIDTH-1:0] pre_ratio;
  logic [RATIO_WIDTH-1:0] core_ratio;
  logic [RATIO_WIDTH-1:0] usb_ratio;
  logic core_src_tick;
  logic usb_src_tick;
  logic ls_violation;
  logic mode_error;
  logic [7:0] core_target;
  logic [7:0] core_source_mhz;
  logic setup_phase;
  logic access_phase;
  logic addr_mapped;
  logic [DATA_WIDTH-1:0] status_word;
  logic [DATA_WIDTH-1:0] config_word;
  logic signed [ACC_WIDTH:0] fast_step;

  // Mode classification drives both clock routing and the legality checks.
  always_comb begin
    pll_mode = (cur.clock_mode_sel == crystal_pll_mode) ||
               (cur.clock_mode_sel == high_speed_crystal_pll_mode) ||
               (cur.clock_mode_sel == external_clock_pll_mode) ||
               (cur.clock_mode_sel == external_clock_pll_io_mode);
    ext_mode = (cur.clock_mode_sel == external_clock_mode) ||
               (cur.clock_mode_sel == external_clock_io_mode) ||
               (cur.clock_mode_sel == external_clock_pll_mode) ||
               (cur.clock_mode_sel == external_clock_pll_io_mode);
    hs_mode = (cur.clock_mode_sel == high_speed_crystal_mode) ||
              (cur.clock_mode_sel == high_speed_crystal_pll_mode);
    primary_mode = ext_mode || hs_mode ||
                   (cur.clock_mode_sel == crystal_mode) ||
                   (cur.clock_mode_sel == crystal_pll_mode);
    mode_defined = primary_mode ||
                   (cur.clock_mode_sel == internal_osc_mode) ||
                   (cur.clock_mode_sel == secondary_osc_mode);
  end

  // Divide ratios for the three dividers.
  always_comb begin
    pre_ratio = prescale_ratio(cur.pll_prescale_sel);
    core_ratio = postscale_ratio(pll_mode, cur.core_postscale_sel);
    if (cur.usb_low_speed) begin
      usb_ratio = USB_LS_DIV;
    end else if (cur.usb_clock_source_sel) begin
      usb_ratio = USB_FS_PLL_DIV;
    end else begin
      usb_ratio = USB_FS_DIRECT_DIV;
    end
  end

  // Source selection. The USB source never looks at the core source, so the
  // core may run from a slow clock while USB keeps the primary oscillator.
  always_comb begin
    if (pll_mode) begin
      core_src_tick = pll_tick;
    end else if (cur.clock_mode_sel == internal_osc_mode) begin
      core_src_tick = cur.fast_tick;
    end else if (cur.clock_mode_sel == secondary_osc_mode) begin
      core_src_tick = sec_osc_tick;
    end else begin
      core_src_tick = osc_tick;
    end
    // Low-speed uses the primary chain, full speed the PLL unless direct.
    if (cur.usb_low_speed || !cur.usb_clock_source_sel) begin
      usb_src_tick = osc_tick;
    end else begin
      usb_src_tick = pll_tick;
    end
  end

  // Legality checks. Only primary modes are held to the 24 MHz core limit;
  // the frequency field is what software tells us the input runs at.
  always_comb begin
    core_source_mhz = pll_mode ? PLL_OUT_MHZ : {2'b00, cur.osc_freq_mhz};
    core_target = LS_CORE_MHZ * {4'h0, core_ratio};
    ls_violation = cur.usb_active_sync && cur.usb_low_speed && primary_mode &&
                   (core_source_mhz != core_target);
    mode_error = !mode_defined;
    if (primary_mode) begin
      if ((cur.pll_prescale_sel == PRESCALE_DIV10_SEL) ||
          (cur.pll_prescale_sel == PRESCALE_DIV12_SEL)) begin
        mode_error = !ext_mode;
      end else if (cur.pll_prescale_sel == PRESCALE_DIV6_SEL) begin
        mode_error = !(ext_mode || hs_mode);
      end
    end
  end

  // Fast oscillator phase step: centre step plus the signed trim.
  always_comb begin
    fast_step = $signed({1'b0, FAST_STEP}) +
                ($signed({{(ACC_WIDTH + 1 - TUNE_WIDTH){cur.tune[TUNE_WIDTH-1]}}, cur.tune})
                <<< TUNE_SHIFT);
  end

  // ----------------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------------
  always_comb begin
    setup_phase = psel && !penable;
    access_phase = psel && penable;
    addr_mapped = (paddr == CONFIG_ADDR) || (paddr == TUNE_ADDR) || (paddr == STATUS_ADDR);
    config_word = '0;
    config_word[MODE_LSB +: 4] = cur.clock_mode_sel;
    config_word[PRESCALE_LSB +: 3] = cur.pll_prescale_sel;
    config_word[POSTSCALE_LSB +: 2] = cur.core_postscale_sel;
    config_word[USB_SRC_BIT] = cur.usb_clock_source_sel;
    config_word[USB_LS_BIT] = cur.usb_low_speed;
    config_word[FREQ_LSB +: FREQ_WIDTH] = cur.osc_freq_mhz;
    status_word = '0;
    status_word[ST_LS_VIOLATION_BIT] = ls_violation;
    status_word[ST_MODE_ERROR_BIT] = mode_error;
    status_word[ST_USB_ACTIVE_BIT] = cur.usb_active_sync;
    status_word[ST_PLL_MODE_BIT] = pll_mode;
    status_word[ST_CORE_RATIO_LSB +: RATIO_WIDTH] = core_ratio;
    status_word[ST_PRESCALE_RATIO_LSB +: RATIO_WIDTH] = pre_ratio;
  end

  // Zero wait states: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = access_phase && !addr_mapped;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    next_cur = cur;

    // Register writes land on the access cycle that completes the transfer.
    if (access_phase && pwrite) begin
      if (paddr == CONFIG_ADDR) begin
        next_cur.clock_mode_sel = clock_mode_type'(pwdata[MODE_LSB +: 4]);
        next_cur.pll_prescale_sel = pwdata[PRESCALE_LSB +: 3];
        next_cur.core_postscale_sel = pwdata[POSTSCALE_LSB +: 2];
        next_cur.usb_clock_source_sel = pwdata[USB_SRC_BIT];
        next_cur.usb_low_speed = pwdata[USB_LS_BIT];
        next_cur.osc_freq_mhz = pwdata[FREQ_LSB +: FREQ_WIDTH];
      end else if (paddr == TUNE_ADDR) begin
        next_cur.tune = pwdata[TUNE_WIDTH-1:0];
      end
    end

    // Read data is captured in the setup cycle so it is steady in access.
    if (setup_phase && !pwrite) begin
      if (paddr == CONFIG_ADDR) begin
        next_cur.prdata = config_word;
      end else if (paddr == TUNE_ADDR) begin
        next_cur.prdata = {{(DATA_WIDTH - TUNE_WIDTH){1'b0}}, cur.tune};
      end else if (paddr == STATUS_ADDR) begin
        next_cur.prdata = status_word;
      end else begin
        next_cur.prdata = '0;
      end
    end

    // The USB activity level comes from an unrelated clock domain.
    next_cur.usb_active_meta = usb_active;
    next_cur.usb_active_sync = cur.usb_active_meta;

    // Input prescaler feeding the PLL reference. A counter beyond a freshly
    // lowered ratio wraps at once instead of running round the full range.
    next_cur.pll_ref_tick = 1'b0;
    if (osc_tick) begin
      if (cur.prescale_cnt >= pre_ratio - RATIO_ONE) begin
        next_cur.prescale_cnt = CNT_ZERO;
        next_cur.pll_ref_tick = 1'b1;
      end else begin
        next_cur.prescale_cnt = cur.prescale_cnt + RATIO_ONE;
      end
    end

    // Core postscaler.
    next_cur.core_tick = 1'b0;
    if (core_src_tick) begin
      if (cur.core_cnt >= core_ratio - RATIO_ONE) begin
        next_cur.core_cnt = CNT_ZERO;
        next_cur.core_tick = 1'b1;
      end else begin
        next_cur.core_cnt = cur.core_cnt + RATIO_ONE;
      end
    end

    // USB clock divider, independent of the core path.
    next_cur.usb_tick = 1'b0;
    if (usb_src_tick) begin
      if (cur.usb_cnt >= usb_ratio - RATIO_ONE) begin
        next_cur.usb_cnt = CNT_ZERO;
        next_cur.usb_tick = 1'b1;
      end else begin
        next_cur.usb_cnt = cur.usb_cnt + RATIO_ONE;
      end
    end

    // Fast internal oscillator: the carry of the phase accumulator is the tick.
    {next_cur.fast_tick, next_cur.fast_acc} =
      (ACC_WIDTH + 1)'({1'b0, cur.fast_acc} + fast_step);

    // Slow RC runs from a fixed divider the trim cannot reach.
    next_cur.slow_tick = 1'b0;
    if (cur.slow_cnt >= SLOW_LAST) begin
      next_cur.slow_cnt = SLOW_ZERO;
      next_cur.slow_tick = 1'b1;
    end else begin
      next_cur.slow_cnt = cur.slow_cnt + SLOW_WIDTH'(1);
    end
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur <= '0;
      cur.clock_mode_sel <= external_clock_mode;
      cur.pll_prescale_sel <= PRESCALE_RESET;
      cur.core_postscale_sel <= POSTSCALE_RESET;
      cur.osc_freq_mhz <= FREQ_RESET;
      cur.tune <= TUNE_RESET;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    prdata = cur.prdata;
    pll_ref_tick = cur.pll_ref_tick;
    core_tick = cur.core_tick;
    usb_tick = cur.usb_tick;
    fast_internal_osc = cur.fast_tick;
    slow_internal_rc = cur.slow_tick;
    osc_tuning_value = cur.tune;
    low_speed_violation = ls_violation;
    mode_not_allowed = mode_error;
  end

endmodule : usb_core_clock_select
`default_nettype wire

// ---- common/clock_select_pkg.sv ----
// Shared constants and types for the USB and core clock selection block.
`default_nettype none
package clock_select_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the APB side)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CONFIG_ADDR = 8'h00;
  localparam logic [7:0] TUNE_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // Control word field positions.
  localparam int MODE_LSB = 0;
  localparam int PRESCALE_LSB = 4;
  localparam int POSTSCALE_LSB = 8;
  localparam int USB_SRC_BIT = 12;
  localparam int USB_LS_BIT = 13;
  localparam int FREQ_LSB = 16;

  // Status word field positions.
  localparam int ST_LS_VIOLATION_BIT = 0;
  localparam int ST_MODE_ERROR_BIT = 1;
  localparam int ST_USB_ACTIVE_BIT = 2;
  localparam int ST_PLL_MODE_BIT = 3;
  localparam int ST_CORE_RATIO_LSB = 4;
  localparam int ST_PRESCALE_RATIO_LSB = 8;

  // ----------------------------------------------------------------------
  // Field widths and reset values
  // ----------------------------------------------------------------------
  localparam int TUNE_WIDTH = 5;
  localparam int FREQ_WIDTH = 6;
  localparam int RATIO_WIDTH = 4;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;
  localparam logic [1:0] POSTSCALE_RESET = 2'h0;
  localparam logic [4:0] TUNE_RESET = 5'h00;
  localparam logic [5:0] FREQ_RESET = 6'h00;

  // Clock mode encodings of clock_mode_sel.
  typedef enum logic [3:0] {
    crystal_mode = 4'h0,
    crystal_pll_mode = 4'h1,
    high_speed_crystal_mode = 4'h2,
    high_speed_crystal_pll_mode = 4'h3,
    external_clock_mode = 4'h4,
    external_clock_io_mode = 4'h5,
    external_clock_pll_mode = 4'h6,
    external_clock_pll_io_mode = 4'h7,
    internal_osc_mode = 4'h8,
    secondary_osc_mode = 4'h9
  } clock_mode_type;

  // ----------------------------------------------------------------------
  // Frequencies and divide ratios
  // ----------------------------------------------------------------------
  localparam logic [7:0] PLL_OUT_MHZ = 8'h60;        // 96 MHz PLL output.
  localparam logic [7:0] LS_CORE_MHZ = 8'h18;        // 24 MHz low-speed core clock.
  localparam logic [3:0] USB_LS_DIV = 4'h4;          // 24 MHz chain to 6 MHz.
  localparam logic [3:0] USB_FS_PLL_DIV = 4'h2;      // 96 MHz PLL to 48 MHz.
  localparam logic [3:0] USB_FS_DIRECT_DIV = 4'h1;   // 48 MHz input taken as is.
  localparam logic [2:0] PRESCALE_DIV6_SEL = 3'h5;
  localparam logic [2:0] PRESCALE_DIV10_SEL = 3'h6;
  localparam logic [2:0] PRESCALE_DIV12_SEL = 3'h7;

  // Fast internal oscillator model: phase step per pclk and tuning weight.
  localparam int ACC_WIDTH = 16;
  localparam logic [15:0] FAST_STEP = 16'h2000;
  localparam int TUNE_SHIFT = 6;

  // Input prescaler ratio for pll_prescale_sel.
  function automatic logic [3:0] prescale_ratio(input logic [2:0] sel);
    case (sel)
      3'h0: prescale_ratio = 4'h1;
      3'h1: prescale_ratio = 4'h2;
      3'h2: prescale_ratio = 4'h3;
      3'h3: prescale_ratio = 4'h4;
      3'h4: prescale_ratio = 4'h5;
      3'h5: prescale_ratio = 4'h6;
      3'h6: prescale_ratio = 4'ha;
      default: prescale_ratio = 4'hc;
    endcase
  endfunction : prescale_ratio

  // Core postscaler ratio; PLL modes divide the 96 MHz PLL output.
  function automatic logic [3:0] postscale_ratio(input logic pll, input logic [1:0] sel);
    case ({pll, sel})
      3'h0: postscale_ratio = 4'h1;
      3'h1: postscale_ratio = 4'h2;
      3'h2: postscale_ratio = 4'h3;
      3'h3: postscale_ratio = 4'h4;
      3'h4: postscale_ratio = 4'h2;
      3'h5: postscale_ratio = 4'h3;
      3'h6: postscale_ratio = 4'h4;
      default: postscale_ratio = 4'h6;
    endcase
  endfunction : postscale_ratio

endpackage : clock_select_pkg
`default_nettype wire

// ---- tb/usb_core_clock_select_sva.sv ----
// Concurrent checks on the ports of the clock selection block.
`timescale 1ns/1ps
`default_nettype none
module usb_core_clock_select_sva
  import clock_select_pkg::*;
#(
  parameter int SLOW_RC_DIV = 6451
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [DATA_WIDTH-1:0] pwdata,
  input wire logic [DATA_WIDTH-1:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic osc_tick,
  input wire logic pll_tick,
  input wire logic usb_active,
  input wire logic pll_ref_tick,
  input wire logic usb_tick,
  input wire logic fast_internal_osc,
  input wire logic slow_internal_rc,
  input wire logic [TUNE_WIDTH-1:0] osc_tuning_value,
  input wire logic low_speed_violation
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------------
  // Helper decode and slow oscillator spacing counter
  // ----------------------------------------------------------------------
  // Decode of the bus request, kept apart so properties stay short.
  wire logic unmapped;
  wire logic tune_wr;
  wire logic [TUNE_WIDTH-1:0] wr_tune;
  assign unmapped = paddr != CONFIG_ADDR && paddr != TUNE_ADDR && paddr != STATUS_ADDR;
  assign tune_wr = psel && penable && pwrite && paddr == TUNE_ADDR;
  assign wr_tune = pwdata[TUNE_WIDTH-1:0];

  // Cycles since the last slow pulse; the first pulse only arms the check.
  logic [31:0] slow_cnt;
  logic slow_seen;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_cnt <= 32'h0;
      slow_seen <= 1'b0;
    end else if (slow_internal_rc) begin
      slow_cnt <= 32'h0;
      slow_seen <= 1'b1;
    end else begin
      slow_cnt <= slow_cnt + 32'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  AST_ERR_UNMAPPED: assert property (psel && penable && unmapped |-> pslverr)
    else $error("unmapped access not flagged");
  AST_ERR_ONLY: assert property (pslverr |-> psel && penable && unmapped)
    else $error("error flagged outside an unmapped access");
  AST_TUNE_WRITE: assert property (tune_wr |=> osc_tuning_value == $past(wr_tune))
    else $error("tuning write not taken");
  AST_TUNE_HOLD: assert property (!tune_wr |=> $stable(osc_tuning_value))
    else $error("tuning value moved without a write");
  AST_TUNE_READ: assert property (psel && !penable && !pwrite && paddr == TUNE_ADDR
    |=> prdata == {27'h0, osc_tuning_value})
    else $error("tuning read data differs from tuning value");
  AST_SLOW_PERIOD: assert property (slow_internal_rc && slow_seen
    |-> slow_cnt == SLOW_RC_DIV - 1)
    else $error("slow oscillator spacing wrong");
  AST_FAST_GAP: assert property (fast_internal_osc |=> !fast_internal_osc)
    else $error("fast oscillator pulses back to back");
  AST_REF_SRC: assert property (pll_ref_tick |-> $past(osc_tick))
    else $error("prescaler pulse without a source tick");
  AST_USB_SRC: assert property (usb_tick |-> $past(osc_tick) || $past(pll_tick))
    else $error("usb pulse without a source tick");
  AST_LS_SYNC: assert property (low_speed_violation |-> $past(usb_active, 2))
    else $error("violation ahead of synchronised usb activity");
endmodule : usb_core_clock_select_sva

bind usb_core_clock_select usb_core_clock_select_sva #(.SLOW_RC_DIV(SLOW_RC_DIV)) u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .osc_tick(osc_tick), .pll_tick(pll_tick), .usb_active(usb_active),
  .pll_ref_tick(pll_ref_tick), .usb_tick(usb_tick), .fast_internal_osc(fast_internal_osc),
  .slow_internal_rc(slow_internal_rc), .osc_tuning_value(osc_tuning_value),
  .low_speed_violation(low_speed_violation));
`default_nettype wire

// ---- tb/usb_core_clock_select_tb.sv ----
// Self-checking bench for the clock selection block, driven over APB.
`timescale 1ns/1ps
`default_nettype none
module usb_core_clock_select_tb
  import clock_select_pkg::*;
;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, osc_tick = 1'b1, pll_tick = 1'b1, sec_osc_tick = 1'b0;
  logic usb_active = 1'b0, pll_ref_tick, core_tick, usb_tick, fast_internal_osc;
  logic slow_internal_rc, low_speed_violation, mode_not_allowed;
  logic [4:0] osc_tuning_value;
  // Pulse outputs gathered into one vector so the spacing loop can index them.
  wire logic [3:0] pulse_vec = {slow_internal_rc, usb_tick, core_tick, pll_ref_tick};
  int error_cnt = 0, checks = 0, per[4], cnt[4], n;
  int pre_ratio[3] = '{6, 10, 12};
  int post_np[4] = '{1, 2, 3, 4};
  int post_pll[4] = '{2, 3, 4, 6};

  usb_core_clock_select #(.SLOW_RC_DIV(8)) u_usb_core_clock_select (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .osc_tick(osc_tick), .pll_tick(pll_tick), .sec_osc_tick(sec_osc_tick),
    .usb_active(usb_active), .pll_ref_tick(pll_ref_tick), .core_tick(core_tick),
    .usb_tick(usb_tick), .fast_internal_osc(fast_internal_osc),
    .slow_internal_rc(slow_internal_rc), .osc_tuning_value(osc_tuning_value),
    .low_speed_violation(low_speed_violation), .mode_not_allowed(mode_not_allowed));

  // 200 MHz clock; the secondary oscillator ticks on every other cycle.
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) sec_osc_tick <= ~sec_osc_tick;

  // Pulse spacing of ref, core, usb and slow outputs, sampled away from the edge.
  always @(negedge pclk) begin
    for (int i = 0; i < 4; i++) begin
      cnt[i]++;
      if (pulse_vec[i] === 1'b1) begin
        per[i] = cnt[i];
        cnt[i] = 0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Bus and check tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request holds until pready is seen at an edge.
  // An idle edge follows the release so that the next call never drives
  // psel twice in one time step.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    chk({31'h0, k < 20}, 32'h1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    @(posedge pclk);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
                        input logic xe);
    apb(1'b0, a, 32'h0);
    chk(r & m, x);
    chk({31'h0, e}, {31'h0, xe});
  endtask : rd_chk

  function automatic logic [31:0] cfg(input logic [3:0] m, input logic [2:0] p,
                                      input logic [1:0] c, input logic s, input logic ls);
    cfg = {10'h0, 6'h18, 2'h0, ls, s, 2'h0, c, 1'b0, p, m};
  endfunction : cfg

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : give_verdict

  // Watchdog, well beyond the 1400 or so cycles the tests need.
  initial begin
    #250000;
    error_cnt++;
    $display("[ERR] %0t watchdog expired", $time);
    give_verdict();
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(CONFIG_ADDR, 32'hffffffff, 32'h4, 1'b0);
    rd_chk(TUNE_ADDR, 32'hffffffff, 32'h0, 1'b0);
    rd_chk(STATUS_ADDR, 32'hfff, 32'h110, 1'b0);
    rd_chk(8'h0c, 32'hffffffff, 32'h0, 1'b1);
    apb(1'b1, 8'h10, 32'h5);
    chk({31'h0, e}, 32'h1);
    apb(1'b1, STATUS_ADDR, 32'hffffffff);
    rd_chk(CONFIG_ADDR, 32'hffffffff, 32'h4, 1'b0);
    $display("test bus_and_reset done");
    // Prescaler codes, checked by pulse spacing with a tick on every cycle.
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, CONFIG_ADDR, cfg(4'h4, 3'(5 + i), 2'h0, 1'b0, 1'b0));
      repeat (40) @(posedge pclk);
      chk(32'(per[0]), 32'(pre_ratio[i]));
      rd_chk(STATUS_ADDR, 32'hf02, 32'(pre_ratio[i]) << 8, 1'b0);
    end
    // Crystal modes are refused on the 40 and 48 MHz prescaler codes.
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, CONFIG_ADDR, cfg(i < 3 ? 4'h2 : 4'h6, 3'(5 + i % 3), 2'h0, 1'b0, 1'b0));
      @(posedge pclk);
      chk({31'h0, mode_not_allowed}, {31'h0, i == 1 || i == 2});
    end
    $display("test prescaler done");
    // Postscaler with low-speed USB active: only a 24 MHz core is clean.
    usb_active <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, CONFIG_ADDR, cfg(i < 4 ? 4'h2 : 4'h3, 3'h5, 2'(i % 4), 1'b0, 1'b1));
      repeat (40) @(posedge pclk);
      n = i < 4 ? post_np[i % 4] : post_pll[i % 4];
      chk(32'(per[1]), 32'(n));
      chk(32'(per[2]), 32'h4);
      chk({31'h0, low_speed_violation}, {31'h0, n != (i < 4 ? 1 : 4)});
      rd_chk(STATUS_ADDR, 32'hfff, {20'h0, 4'(n) == 4'h0 ? 4'h0 : 4'h6, 4'(n),
                                    i >= 4, 3'(4 + (n != (i < 4 ? 1 : 4)))}, 1'b0);
    end
    // Internal and secondary sources lift the 24 MHz limit.
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, CONFIG_ADDR, cfg(4'(8 + i), 3'h5, 2'h1, 1'b0, 1'b1));
      repeat (4) @(posedge pclk);
      chk({31'h0, low_speed_violation}, 32'h0);
    end
    // Full speed: PLL source halves, direct source passes each tick.
    for (int i = 0; i < 2; i++) begin
      apb(1'b1, CONFIG_ADDR, cfg(4'h6, 3'h7, 2'h0, 1'(1 - i), 1'b0));
      repeat (20) @(posedge pclk);
      chk(32'(per[2]), 32'(2 - i));
    end
    $display("test postscaler_usb done");
    // Trim steps the fast oscillator only; unused write bits are dropped.
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, TUNE_ADDR, i == 0 ? 32'hffffffef : (i == 1 ? 32'h0 : 32'h10));
      rd_chk(TUNE_ADDR, 32'hffffffff, i == 0 ? 32'hf : (i == 1 ? 32'h0 : 32'h10), 1'b0);
      chk({27'h0, osc_tuning_value}, i == 0 ? 32'hf : (i == 1 ? 32'h0 : 32'h10));
      n = 0;
      repeat (256) begin
        @(negedge pclk);
        if (fast_internal_osc === 1'b1) n++;
      end
      chk({31'h0, i == 0 ? (n == 35 || n == 36) : n == (i == 1 ? 32 : 28)}, 32'h1);
      chk(32'(per[3]), 32'h8);
    end
    $display("test tuning done");
    give_verdict();
  end
endmodule : usb_core_clock_select_tb
`default_nettype wire
